// ===== logic/io_wdt_pkg.sv
package io_wdt_pkg;

    // I/O port decode
    localparam logic [15:0] DISABLE_PORT = 16'h0043;
    localparam logic [15:0] TRIGGER_PORT = 16'h0443;

    // Timeout field within the written byte
    localparam int          TMO_W        = 6;
    localparam logic [5:0]  TMO_MIN      = 6'h01;
    localparam logic [5:0]  TMO_MAX      = 6'h3f;

    // Time base: one second at the 20 MHz reference
    localparam int          CLK_HZ       = 20000000;
    localparam int          TICK_SEC     = 1;
    localparam int          TICK_CYC     = CLK_HZ * TICK_SEC;

    // Length of the reset pulse given on expiry
    localparam int          RST_PULSE_CYC = 16;

    // Pin input synchroniser depth
    localparam int          SYNC_DEPTH   = 3;

endpackage

// ===== logic/io_port_watchdog_timer.sv
`timescale 1ns/1ps

// Behaviour
// - Trigger write loads timeout and restarts countdown
// - Timeout accepted from 01 to 3F only
// - One count equals one second of timeout
// - Disable port read stops watchdog until write
module io_port_watchdog_timer #(
    parameter int TICK_CYCLES = io_wdt_pkg::TICK_CYC,       // Cycles per second tick
    parameter int PULSE_CYCLES = io_wdt_pkg::RST_PULSE_CYC  // Reset pulse length
) (
    input  wire logic        ref_clk_i,   // 20 MHz clock
    input  wire logic        rst_i,       // Async reset, active high
    input  wire logic [15:0] io_addr_i,   // I/O address
    input  wire logic [7:0]  io_wdata_i,  // I/O write data
    input  wire logic        io_wr_n_i,   // I/O write strobe, active low
    input  wire logic        io_rd_n_i,   // I/O read strobe, active low
    output logic             active_o,    // Watchdog running
    output logic [5:0]       remain_o,    // Seconds left
    output logic             sys_rst_o    // System reset pulse
);

    ////////////////////////////////////////////////////////////////////////
    // Parameter checks

    // The tick counter wraps at TICK_CYCLES - 1, so a one-cycle second would
    // never let the partial-second counter restart cleanly on a trigger.
    // A zero-length pulse would leave the reset state with nothing to count.
    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("watchdog: tick length must be at least two cycles");
    end
    if (PULSE_CYCLES < 1) begin : g_bad_pulse
        $error("watchdog: reset pulse must be at least one cycle");
    end
    // The strobe logic compares stages two and three of the synchroniser
    if (io_wdt_pkg::SYNC_DEPTH != 3) begin : g_bad_sync
        $error("watchdog: strobe synchroniser must be three stages");
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Full 16-bit match; aliases of either port are not decoded, so a host
    // that only drives the low address byte will not reach the watchdog.
    function automatic logic port_hit(input logic [15:0] addr,
                                      input logic [15:0] port);
        return addr == port;
    endfunction

    // A timeout byte is usable only inside the documented range; the two top
    // bits must be clear, otherwise the value would alias into the range.
    function automatic logic timeout_ok(input logic [7:0] data);
        return data[7:6] == 2'h0 &&
               data[5:0] >= io_wdt_pkg::TMO_MIN &&
               data[5:0] <= io_wdt_pkg::TMO_MAX;
    endfunction

    // Level of a strobe once the two oldest stages agree on it
    function automatic logic sync_level(input logic [2:0] sync);
        return sync[1] & sync[2];
    endfunction

    // True once the two oldest stages show the same value
    function automatic logic sync_agree(input logic [2:0] sync);
        return sync[1] == sync[2];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_RESET = 3'b100
    } wd_state_type;

    typedef struct packed {
        logic [2:0]  wr_sync;
        logic [2:0]  rd_sync;
        logic        wr_seen;
        logic        rd_seen;
        wd_state_type st;
        logic [5:0]  secs;
        logic [31:0] tick_cnt;
        logic [31:0] pulse_cnt;
        logic        active;
        logic        sys_rst;
    } wd_regs_type;

    wd_regs_type s_r;
    wd_regs_type s_nxt;

    // Strobes are asynchronous pins; address and data are assumed stable
    // while a strobe is low, so only the strobes need synchronising.
    logic wr_lvl;
    logic rd_lvl;
    logic wr_evt;
    logic rd_evt;
    logic hit_trig;
    logic hit_dis;
    logic tick;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    // The strobes are shifted in active high, so an idle bus (strobes high)
    // gives all-zero stages and no false event after reset. Only the
    // second and third stages are read by the decode below.
    always_comb begin
        s_nxt = s_r;
        s_nxt.wr_sync = {s_r.wr_sync[1:0], ~io_wr_n_i};
        s_nxt.rd_sync = {s_r.rd_sync[1:0], ~io_rd_n_i};
        // A change counts once stages two and three agree
        wr_lvl = sync_level(s_r.wr_sync);
        rd_lvl = sync_level(s_r.rd_sync);
        // One event per strobe low period, however long the host holds it
        wr_evt = wr_lvl & ~s_r.wr_seen;
        rd_evt = rd_lvl & ~s_r.rd_seen;
        if (sync_agree(s_r.wr_sync))
            s_nxt.wr_seen = wr_lvl;
        if (sync_agree(s_r.rd_sync))
            s_nxt.rd_seen = rd_lvl;
        // Address is taken at the event edge; it must still stand then
        hit_trig = wr_evt && port_hit(io_addr_i, io_wdt_pkg::TRIGGER_PORT);
        hit_dis  = rd_evt && port_hit(io_addr_i, io_wdt_pkg::DISABLE_PORT);
        tick     = s_r.tick_cnt == 32'(TICK_CYCLES - 1);

        case (s_r.st)
            ST_IDLE, ST_RUN: begin
                // The second counter only runs while armed, so an idle
                // watchdog draws no toggling from the long counter.
                if (s_r.st == ST_RUN)
                    s_nxt.tick_cnt = tick ? 32'h0 : s_r.tick_cnt + 32'h1;
                if (hit_trig && timeout_ok(io_wdata_i)) begin
                    // Out-of-range values are ignored, leaving state as it was
                    s_nxt.secs     = io_wdata_i[5:0];
                    s_nxt.tick_cnt = 32'h0;
                    s_nxt.st       = ST_RUN;
                    s_nxt.active   = 1'b1;
                end else if (hit_dis) begin
                    s_nxt.st     = ST_IDLE;
                    s_nxt.active = 1'b0;
                end else if (s_r.st == ST_RUN && tick) begin
                    if (s_r.secs == 6'h01) begin
                        // Host missed its refresh window
                        s_nxt.st        = ST_RESET;
                        s_nxt.secs      = 6'h0;
                        s_nxt.active    = 1'b0;
                        s_nxt.sys_rst   = 1'b1;
                        s_nxt.pulse_cnt = 32'h0;
                    end else begin
                        s_nxt.secs = s_r.secs - 6'h01;
                    end
                end
            end
            ST_RESET: begin
                // Trigger is ignored while the reset pulse is out
                s_nxt.pulse_cnt = s_r.pulse_cnt + 32'h1;
                if (s_r.pulse_cnt == 32'(PULSE_CYCLES - 1)) begin
                    s_nxt.sys_rst = 1'b0;
                    s_nxt.st      = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st      = ST_IDLE;
                s_nxt.active  = 1'b0;
                s_nxt.sys_rst = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // Every output is a field of this one register, so none of them can
    // glitch while the next-state logic settles.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '{wr_sync: 3'h0, rd_sync: 3'h0, wr_seen: 1'b0, rd_seen: 1'b0,
                     st: ST_IDLE, secs: 6'h0, tick_cnt: 32'h0, pulse_cnt: 32'h0,
                     active: 1'b0, sys_rst: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Plain wires from register fields; remain_o holds its last value after
    // a disable, so software can see how close the host came to expiry.
    assign active_o  = s_r.active;
    assign remain_o  = s_r.secs;
    assign sys_rst_o = s_r.sys_rst;

endmodule

// ===== test/wdt_asserts.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Strobes reach the outputs two to five edges late through the synchroniser
module wdt_asserts #(
    parameter int PULSE_CYCLES = 4  // Reset pulse length
) (
    input wire logic        ref_clk_i,  // Clock
    input wire logic        rst_i,      // Reset
    input wire logic [15:0] io_addr_i,  // Address
    input wire logic [7:0]  io_wdata_i, // Data
    input wire logic        io_wr_n_i,  // Write
    input wire logic        io_rd_n_i,  // Read
    input wire logic        active_o,   // Running
    input wire logic [5:0]  remain_o,   // Seconds
    input wire logic        sys_rst_o   // Pulse
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_trig_load: assert property (
        $fell(io_wr_n_i) && io_addr_i == 16'h0443 && io_wdata_i inside {[8'h01:8'h3f]}
        && !sys_rst_o |-> ##[2:5] active_o && remain_o == io_wdata_i[5:0])
        else $error("trigger write not loaded");
    a_bad_ignored: assert property (
        $fell(io_wr_n_i) && io_addr_i == 16'h0443 && !active_o
        && (io_wdata_i == 8'h00 || io_wdata_i > 8'h3f) |-> (!active_o)[*6])
        else $error("bad timeout armed watchdog");
    // Stable span assumes the ten-cycle second used in simulation
    a_one_second: assert property (
        $rose(active_o) && remain_o > 6'h01 |=> $stable(remain_o)[*7]
        ##[1:3] remain_o + 6'h01 == $past(remain_o))
        else $error("second tick mistimed");
    a_disable_off: assert property (
        $fell(io_rd_n_i) && io_addr_i == 16'h0043 && !sys_rst_o |-> ##[2:5] !active_o)
        else $error("disable read ignored");
    a_expiry_pulse: assert property (
        $rose(sys_rst_o) |-> !active_o && $past(remain_o) == 6'h01
        ##PULSE_CYCLES $fell(sys_rst_o))
        else $error("expiry pulse wrong");
endmodule
bind io_port_watchdog_timer wdt_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.*);

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [15:0] io_addr_i = 16'h0000;
    logic [7:0]  io_wdata_i = 8'h00;
    logic        io_wr_n_i = 1'b1;
    logic        io_rd_n_i = 1'b1;
    logic        active_o;
    logic [5:0]  remain_o;
    logic        sys_rst_o;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          n;
    always #25 ref_clk_i = ~ref_clk_i;
    // Short second keeps the run brief
    io_port_watchdog_timer #(.TICK_CYCLES(10), .PULSE_CYCLES(4)) DUT (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .io_addr_i  (io_addr_i),
        .io_wdata_i (io_wdata_i),
        .io_wr_n_i  (io_wr_n_i),
        .io_rd_n_i  (io_rd_n_i),
        .active_o   (active_o),
        .remain_o   (remain_o),
        .sys_rst_o  (sys_rst_o)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobe low five cycles, high four, so each access clears the sync
    task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic wr);
        io_addr_i = a;
        io_wdata_i = d;
        if (wr) io_wr_n_i = 1'b0; else io_rd_n_i = 1'b0;
        step(5);
        io_wr_n_i = 1'b1;
        io_rd_n_i = 1'b1;
        step(4);
    endtask
    task automatic t_bad;
        acc(16'h0443, 8'h00, 1'b1);
        acc(16'h0443, 8'h40, 1'b1);
        acc(16'h0444, 8'h05, 1'b1);
        chk(active_o, 8'h00);
    endtask
    task automatic t_refresh;
        acc(16'h0443, 8'h3f, 1'b1);
        chk(remain_o, 8'h3f);
        step(12);
        acc(16'h0443, 8'h03, 1'b1);
        chk(remain_o, 8'h03);
        acc(16'h0043, 8'h00, 1'b0);
        step(45);
        chk(active_o, 8'h00);
        chk(remain_o, 8'h03);
    endtask
    task automatic t_expire;
        acc(16'h0443, 8'h02, 1'b1);
        chk(remain_o, 8'h02);
        n = 0;
        while (!sys_rst_o && n < 40) begin step(1); n++; end
        chk(remain_o + active_o, 8'h00);
        n = 0;
        while (sys_rst_o && n < 20) begin step(1); n++; end
        chk(n[7:0], 8'h04);
    endtask
    task automatic finish_test;
        $display("checks=%0d fails=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin #50000; n_fail++; finish_test; end
    initial begin
        step(4);
        rst_i = 1'b0;
        step(1);
        t_bad;
        t_refresh;
        t_expire;
        finish_test;
    end
endmodule
